/* rtl/comm_cfg_pkg.sv */
package comm_cfg_pkg;
    localparam logic [15:0] OFS_NODE_ADDR  = 16'h0300;
    localparam logic [15:0] OFS_SPEED      = 16'h0302;
    localparam logic [15:0] OFS_PROTOCOL   = 16'h0304;
    localparam logic [15:0] OFS_FAULT_ACT  = 16'h0306;
    localparam logic [15:0] OFS_TIMEOUT    = 16'h0308;
    localparam logic [15:0] OFS_PHY_SEL    = 16'h030a;
    localparam logic [15:0] OFS_REPLY_DLY  = 16'h030e;

    localparam logic [15:0] RST_NODE_ADDR  = 16'h007f;
    localparam logic [15:0] RST_SPEED      = 16'h0203;
    localparam logic [15:0] RST_PROTOCOL   = 16'h0006;
    localparam logic [15:0] RST_FAULT_ACT  = 16'h0000;
    localparam logic [15:0] RST_TIMEOUT    = 16'h0000;
    localparam logic [15:0] RST_PHY_SEL    = 16'h0000;
    localparam logic [15:0] RST_REPLY_DLY  = 16'h0000;

    localparam logic [7:0]  ADDR_MIN       = 8'h01;
    localparam logic [7:0]  ADDR_MAX       = 8'h7f;
    localparam logic [7:0]  ADDR_ANY       = 8'hff;
    localparam logic [15:0] SPEED_MAX      = 16'h0405;
    localparam logic [3:0]  UART_RATE_MAX  = 4'h5;
    localparam logic [3:0]  CAN_RATE_MAX   = 4'h4;
    localparam logic [3:0]  PROTO_MAX      = 4'h8;
    localparam logic [3:0]  PROTO_RTU_MIN  = 4'h6;
    localparam logic [4:0]  TIMEOUT_MAX    = 5'h14;
    localparam logic [10:0] DELAY_MAX      = 11'h3e8;

    localparam int          CLK_HZ         = 250000000;
    localparam int          MS_CYCLES      = CLK_HZ / 1000;
    localparam int          SEC_MS         = 1000;
    localparam logic [17:0] MS_TICK_LAST   = 18'(MS_CYCLES - 1);
    localparam logic [9:0]  SEC_MS_LAST    = 10'(SEC_MS - 1);
    localparam int          USB_KBPS       = 1000;

    typedef enum logic [1:0] {
        DLY_IDLE = 2'b00,
        DLY_WAIT = 2'b01,
        DLY_SEND = 2'b10
    } reply_state_t;

    typedef struct packed {
        logic [2:0] uart_rate;
        logic [2:0] can_rate;
        logic       ascii_mode;
        logic       eight_bits;
        logic       parity_en;
        logic       parity_odd;
        logic       two_stop;
        logic       rs485_sel;
    } link_cfg_t;
endpackage

/* rtl/serial_slave_comm_config.sv */
`timescale 1ns/1ps
// Summary of operation
// - node address register takes 0x01..0x7f, resets to 0x7f
// - low digit is axis number, next digit group 0..7, upper digits zero
// - no broadcast address exists; only a frame for 0xff is taken by every node
// - frame addressed 0xff is accepted and answered whatever our address
// - speed digit 0 picks uart baud 4800..115200 for codes 0..5
// - speed digit 2 picks can rate 125k..1m for codes 0..4
// - speed digit 1 reserved zero; range 0x0000..0x0405, reset 0x0203
// - speed writes over canopen change only the can rate digit; other registers take the whole word
// - usb path always runs at 1 mbit/s
// - protocol codes 0..5 are modbus ascii 7n2 7e1 7o1 8n2 8e1 8o1
// - codes 6..8 are modbus rtu 8n2 default, 8e1, 8o1
// - fault action 0 shows fault, drive keeps running
// - fault action 1 shows fault and asks for a decelerated stop
// - timeout 1..20 s raises fault after that long without traffic
// - timeout zero disables detection
// - interface select 0 is rs-232, 1 is rs-485, never mixed
// - each reply is held back 0..1000 ms
module serial_slave_comm_config #(
    parameter int                         MS_CYCLES = comm_cfg_pkg::MS_CYCLES // clocks per ms
) (
    input  wire logic                     clk_sys_i,      // 250 mhz system clock
    input  wire logic                     reset_n_i,      // synchronous reset, active low
    input  wire logic                     reg_wr_i,       // register write strobe
    input  wire logic                     reg_rd_i,       // register read strobe
    input  wire logic                     reg_canopen_i,  // write comes over canopen
    input  wire logic [15:0]              reg_addr_i,     // parameter address
    input  wire logic [15:0]              reg_wdata_i,    // write data
    output logic      [15:0]              reg_rdata_o,    // read data
    output logic                          reg_ack_o,      // access accepted
    output logic                          reg_err_o,      // write unmapped or out of range
    input  wire logic                     frame_valid_i,  // one-cycle: frame received
    input  wire logic [7:0]               frame_addr_i,   // address field of frame
    output logic                          frame_accept_o, // frame is for this drive
    output logic                          frame_drop_o,   // frame discarded
    output logic                          reply_go_o,     // one-cycle: send reply now
    output logic                          reply_busy_o,   // reply delay running
    output comm_cfg_pkg::link_cfg_t       link_cfg_o,     // decoded framing setup
    output logic [3:0]                    axis_num_o,     // axis number
    output logic [2:0]                    group_num_o,    // group number
    output logic                          usb_1m_o,       // usb rate fixed 1 mbit/s
    output logic                          comm_fault_o,   // timeout fault shown
    output logic                          decel_stop_o    // stop request on fault
);
    logic [15:0] node_addr_reg, node_addr_next;
    logic [15:0] speed_reg, speed_next;
    logic [15:0] proto_reg, proto_next;
    logic [15:0] fault_act_reg, fault_act_next;
    logic [15:0] timeout_reg, timeout_next;
    logic [15:0] phy_reg, phy_next;
    logic [15:0] dly_reg, dly_next;
    logic [17:0] tick_reg, tick_next;
    logic [9:0]  ms_reg, ms_next;
    logic [4:0]  sec_reg, sec_next;
    logic        fault_reg, fault_next;
    logic [10:0] wait_reg, wait_next;
    comm_cfg_pkg::reply_state_t st_reg, st_next;
    logic        hit, wr_ok, ms_tick, sec_tick;
    logic [15:0] rdata_next;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] d);
        logic ok;
        ok = 1'b0;
        case (a)
            comm_cfg_pkg::OFS_NODE_ADDR:
                ok = d[15:8] == 8'h00 && d[7:0] >= comm_cfg_pkg::ADDR_MIN
                     && d[7:0] <= comm_cfg_pkg::ADDR_MAX;
            comm_cfg_pkg::OFS_SPEED:
                ok = d[15:12] == 4'h0 && d[11:8] <= comm_cfg_pkg::CAN_RATE_MAX
                     && d[7:4] == 4'h0 && d[3:0] <= comm_cfg_pkg::UART_RATE_MAX;
            comm_cfg_pkg::OFS_PROTOCOL:
                ok = d <= 16'(comm_cfg_pkg::PROTO_MAX);
            comm_cfg_pkg::OFS_FAULT_ACT,
            comm_cfg_pkg::OFS_PHY_SEL:
                ok = d <= 16'h0001;
            comm_cfg_pkg::OFS_TIMEOUT:
                ok = d <= 16'(comm_cfg_pkg::TIMEOUT_MAX);
            comm_cfg_pkg::OFS_REPLY_DLY:
                ok = d <= 16'(comm_cfg_pkg::DELAY_MAX);
            default:
                ok = 1'b0;
        endcase
        return ok;
    endfunction

    // canopen may only touch the can digit, so range-check the merged word
    logic [15:0] wdata_eff;
    always_comb
    begin
        wdata_eff = reg_wdata_i;
        if (reg_canopen_i && reg_addr_i == comm_cfg_pkg::OFS_SPEED)
        begin
            wdata_eff = {speed_reg[15:12], reg_wdata_i[11:8], speed_reg[7:0]};
        end
    end

    assign wr_ok = reg_wr_i && in_range(reg_addr_i, wdata_eff);

    always_comb
    begin
        node_addr_next = node_addr_reg;
        speed_next     = speed_reg;
        proto_next     = proto_reg;
        fault_act_next = fault_act_reg;
        timeout_next   = timeout_reg;
        phy_next       = phy_reg;
        dly_next       = dly_reg;
        if (wr_ok)
        begin
            case (reg_addr_i)
                comm_cfg_pkg::OFS_NODE_ADDR: node_addr_next = wdata_eff;
                comm_cfg_pkg::OFS_SPEED:     speed_next = wdata_eff;
                comm_cfg_pkg::OFS_PROTOCOL:  proto_next = wdata_eff;
                comm_cfg_pkg::OFS_FAULT_ACT: fault_act_next = wdata_eff;
                comm_cfg_pkg::OFS_TIMEOUT:   timeout_next = wdata_eff;
                comm_cfg_pkg::OFS_PHY_SEL:   phy_next = wdata_eff;
                comm_cfg_pkg::OFS_REPLY_DLY: dly_next = wdata_eff;
                default:                     dly_next = dly_reg;
            endcase
        end
        case (reg_addr_i)
            comm_cfg_pkg::OFS_NODE_ADDR: rdata_next = node_addr_reg;
            comm_cfg_pkg::OFS_SPEED:     rdata_next = speed_reg;
            comm_cfg_pkg::OFS_PROTOCOL:  rdata_next = proto_reg;
            comm_cfg_pkg::OFS_FAULT_ACT: rdata_next = fault_act_reg;
            comm_cfg_pkg::OFS_TIMEOUT:   rdata_next = timeout_reg;
            comm_cfg_pkg::OFS_PHY_SEL:   rdata_next = phy_reg;
            comm_cfg_pkg::OFS_REPLY_DLY: rdata_next = dly_reg;
            default:                     rdata_next = 16'h0000;
        endcase
        if (!reg_rd_i)
        begin
            rdata_next = reg_rdata_o;
        end
    end

    // address match: own node or respond-to-any, never a broadcast
    assign hit = frame_valid_i && (frame_addr_i == node_addr_reg[7:0]
                 || frame_addr_i == comm_cfg_pkg::ADDR_ANY);

    // timeout: 1 ms prescaler, then ms to seconds
    // prescale length is a parameter so short runs can reach the ms and second paths
    assign ms_tick  = tick_reg == 18'(MS_CYCLES - 1);
    assign sec_tick = ms_tick && ms_reg == comm_cfg_pkg::SEC_MS_LAST;

    always_comb
    begin
        tick_next  = ms_tick ? 18'h00000 : tick_reg + 18'h00001;
        ms_next    = ms_reg;
        sec_next   = sec_reg;
        fault_next = fault_reg;
        if (ms_tick)
        begin
            ms_next = sec_tick ? 10'h000 : ms_reg + 10'h001;
        end
        if (sec_tick && sec_reg != comm_cfg_pkg::TIMEOUT_MAX)
        begin
            sec_next = sec_reg + 5'h01;
        end
        if (timeout_reg == 16'h0000)
        begin
            fault_next = 1'b0;
        end
        else if (sec_tick && 16'(sec_reg + 5'h01) >= timeout_reg)
        begin
            fault_next = 1'b1;
        end
        // a restart, by an accepted frame or a timeout write, also drops the shown fault
        if (hit || (wr_ok && reg_addr_i == comm_cfg_pkg::OFS_TIMEOUT))
        begin
            tick_next = 18'h00000;
            ms_next   = 10'h000;
            sec_next  = 5'h00;
            fault_next = 1'b0;
        end
    end

    // reply delay; a new frame during the wait does not reload wait_reg and gets no reply of its own
    always_comb
    begin
        st_next   = st_reg;
        wait_next = wait_reg;
        case (st_reg)
            comm_cfg_pkg::DLY_IDLE:
            begin
                if (hit)
                begin
                    wait_next = dly_reg[10:0];
                    st_next   = (dly_reg == 16'h0000) ? comm_cfg_pkg::DLY_SEND
                                                      : comm_cfg_pkg::DLY_WAIT;
                end
            end
            comm_cfg_pkg::DLY_WAIT:
            begin
                if (ms_tick)
                begin
                    wait_next = wait_reg - 11'h001;
                    if (wait_reg == 11'h001)
                    begin
                        st_next = comm_cfg_pkg::DLY_SEND;
                    end
                end
            end
            comm_cfg_pkg::DLY_SEND:
                st_next = comm_cfg_pkg::DLY_IDLE;
            default:
                st_next = comm_cfg_pkg::DLY_IDLE;
        endcase
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            node_addr_reg <= comm_cfg_pkg::RST_NODE_ADDR;
            speed_reg     <= comm_cfg_pkg::RST_SPEED;
            proto_reg     <= comm_cfg_pkg::RST_PROTOCOL;
            fault_act_reg <= comm_cfg_pkg::RST_FAULT_ACT;
            timeout_reg   <= comm_cfg_pkg::RST_TIMEOUT;
            phy_reg       <= comm_cfg_pkg::RST_PHY_SEL;
            dly_reg       <= comm_cfg_pkg::RST_REPLY_DLY;
            tick_reg      <= 18'h00000;
            ms_reg        <= 10'h000;
            sec_reg       <= 5'h00;
            fault_reg     <= 1'b0;
            wait_reg      <= 11'h000;
            st_reg        <= comm_cfg_pkg::DLY_IDLE;
            reg_rdata_o   <= 16'h0000;
            reg_ack_o     <= 1'b0;
            reg_err_o     <= 1'b0;
        end
        else
        begin
            node_addr_reg <= node_addr_next;
            speed_reg     <= speed_next;
            proto_reg     <= proto_next;
            fault_act_reg <= fault_act_next;
            timeout_reg   <= timeout_next;
            phy_reg       <= phy_next;
            dly_reg       <= dly_next;
            tick_reg      <= tick_next;
            ms_reg        <= ms_next;
            sec_reg       <= sec_next;
            fault_reg     <= fault_next;
            wait_reg      <= wait_next;
            st_reg        <= st_next;
            reg_rdata_o   <= rdata_next;
            reg_ack_o     <= wr_ok || reg_rd_i;
            reg_err_o     <= reg_wr_i && !wr_ok;
        end
    end

    always_comb
    begin
        link_cfg_o.uart_rate  = speed_reg[2:0];
        link_cfg_o.can_rate   = speed_reg[10:8];
        link_cfg_o.ascii_mode = proto_reg[3:0] < comm_cfg_pkg::PROTO_RTU_MIN;
        link_cfg_o.eight_bits = proto_reg[3:0] >= 4'h3;
        link_cfg_o.parity_en  = proto_reg[3:0] != 4'h0 && proto_reg[3:0] != 4'h3
                                && proto_reg[3:0] != 4'h6;
        link_cfg_o.parity_odd = proto_reg[3:0] == 4'h2 || proto_reg[3:0] == 4'h5
                                || proto_reg[3:0] == 4'h8;
        link_cfg_o.two_stop   = !link_cfg_o.parity_en;
        link_cfg_o.rs485_sel  = phy_reg[0];
    end

    assign axis_num_o     = node_addr_reg[3:0];
    assign group_num_o    = node_addr_reg[6:4];
    assign usb_1m_o       = 1'b1;
    assign frame_accept_o = hit;
    assign frame_drop_o   = frame_valid_i && !hit;
    assign reply_go_o     = st_reg == comm_cfg_pkg::DLY_SEND;
    assign reply_busy_o   = st_reg != comm_cfg_pkg::DLY_IDLE;
    assign comm_fault_o   = fault_reg;
    assign decel_stop_o   = fault_reg && fault_act_reg[0];

    AST_ADDR_RANGE: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        node_addr_reg[7:0] >= comm_cfg_pkg::ADDR_MIN && node_addr_reg[15:7] == 9'h000)
        else $error("node address out of range");
    AST_SPEED_RSV: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        speed_reg[7:4] == 4'h0 && speed_reg <= comm_cfg_pkg::SPEED_MAX)
        else $error("speed register reserved digit or range broken");
    AST_CAN_ONLY: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        reg_wr_i && reg_canopen_i && reg_addr_i == comm_cfg_pkg::OFS_SPEED
        |=> speed_reg[7:0] == $past(speed_reg[7:0]))
        else $error("canopen write changed uart digit");
    AST_ANY_ACCEPT: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        frame_valid_i && frame_addr_i == comm_cfg_pkg::ADDR_ANY |-> frame_accept_o)
        else $error("respond-to-any frame not accepted");
    AST_DROP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        frame_drop_o && st_reg == comm_cfg_pkg::DLY_IDLE |=> st_reg == comm_cfg_pkg::DLY_IDLE)
        else $error("dropped frame started a reply");
    AST_NO_DELAY: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        hit && st_reg == comm_cfg_pkg::DLY_IDLE && dly_reg == 16'h0000 |=> reply_go_o)
        else $error("zero-delay reply not sent next cycle");
    AST_TO_OFF: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        timeout_reg == 16'h0000 |=> !comm_fault_o)
        else $error("fault raised with timeout disabled");
    AST_RESTART: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        hit |=> sec_reg == 5'h00 && ms_reg == 10'h000 && !comm_fault_o)
        else $error("timeout not restarted by frame");
    AST_STOP: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        comm_fault_o && fault_act_reg == 16'h0000 |-> !decel_stop_o)
        else $error("stop requested while action is continue");
    AST_PROTO: assert property (@(posedge clk_sys_i) disable iff (!reset_n_i)
        proto_reg == 16'h0006 |-> !link_cfg_o.ascii_mode && link_cfg_o.two_stop
        && link_cfg_o.eight_bits)
        else $error("rtu default framing wrong");
    COV_ANY: cover property (@(posedge clk_sys_i) frame_valid_i && frame_addr_i == 8'hff);
    COV_DELAY: cover property (@(posedge clk_sys_i) st_reg == comm_cfg_pkg::DLY_WAIT
        ##1 reply_go_o);
    COV_FAULT: cover property (@(posedge clk_sys_i) decel_stop_o);
endmodule

/* testbench/host_frame_model.sv */
`timescale 1ns/1ps
// host side of the serial link: one frame pulse per call, address released after
module host_frame_model (
    input  wire logic       clk_i,          // system clock
    output logic            frame_valid_o,  // one-cycle frame strobe
    output logic [7:0]      frame_addr_o    // frame address byte
);
    initial
    begin
        frame_valid_o = 1'b0;
        frame_addr_o  = 8'h00;
    end

    // a slow host just idles some cycles first; one target per frame keeps
    // addresses unique on the ring and never programs the any-address value
    task automatic send(input logic [7:0] a, input int gap);
        repeat (gap + 1) @(negedge clk_i);
        frame_valid_o = 1'b1;
        frame_addr_o  = a;
    endtask

    // released byte shows the inverse, so a stale match cannot hide
    task automatic finish;
        @(negedge clk_i);
        frame_valid_o = 1'b0;
        frame_addr_o  = ~frame_addr_o;
    endtask
endmodule

/* testbench/test_serial_slave_comm_config.sv */
`timescale 1ns/1ps
module test_serial_slave_comm_config;
    logic                      clk_sys_i = 1'b0;
    logic                      reset_n_i = 1'b0;
    logic                      reg_wr_i = 1'b0;
    logic                      reg_rd_i = 1'b0;
    logic                      reg_canopen_i = 1'b0;
    logic [15:0]               reg_addr_i = 16'h0000;
    logic [15:0]               reg_wdata_i = 16'h0000;
    logic [15:0]               reg_rdata_o;
    logic                      reg_ack_o, reg_err_o;
    logic                      frame_valid_i, frame_accept_o, frame_drop_o;
    logic [7:0]                frame_addr_i;
    logic                      reply_go_o, reply_busy_o;
    comm_cfg_pkg::link_cfg_t   link_cfg_o;
    logic [3:0]                axis_num_o;
    logic [2:0]                group_num_o;
    logic                      usb_1m_o, comm_fault_o, decel_stop_o;
    int                        n_errors = 0;
    int                        checks_done = 0;
    int                        cycles = 0;
    // {ascii, eight bits, parity on, odd, two stop} for codes 0..8
    localparam logic [4:0]     PT[9] = '{5'h11, 5'h14, 5'h16, 5'h19, 5'h1c, 5'h1e,
                                         5'h09, 5'h0c, 5'h0e};

    // short millisecond so reply delay and timeout finish within the run
    localparam int             MS = 10;

    always #2 clk_sys_i = ~clk_sys_i;

    host_frame_model u_host (.clk_i(clk_sys_i), .frame_valid_o(frame_valid_i),
                             .frame_addr_o(frame_addr_i));

    serial_slave_comm_config #(.MS_CYCLES(MS)) u_dut (
        .clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_canopen_i(reg_canopen_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .reg_ack_o(reg_ack_o),
        .reg_err_o(reg_err_o), .frame_valid_i(frame_valid_i), .frame_addr_i(frame_addr_i),
        .frame_accept_o(frame_accept_o), .frame_drop_o(frame_drop_o),
        .reply_go_o(reply_go_o), .reply_busy_o(reply_busy_o), .link_cfg_o(link_cfg_o),
        .axis_num_o(axis_num_o), .group_num_o(group_num_o), .usb_1m_o(usb_1m_o),
        .comm_fault_o(comm_fault_o), .decel_stop_o(decel_stop_o));

    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // generous ceiling: the one-second timeout test dominates at about 10000 cycles
    always @(posedge clk_sys_i)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %0t run did not finish", $time);
            complete_run();
        end
    end

    task automatic check_word(input logic [15:0] got, input logic [15:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            n_errors = n_errors + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_word({15'h0000, got}, {15'h0000, exp});
    endtask

    // strobe taken at the next rising edge, answer sampled one cycle on
    task automatic bus(input logic wr, input logic [15:0] a, input logic [15:0] d,
                       output logic ack, output logic err, output logic [15:0] q);
        @(negedge clk_sys_i);
        reg_wr_i = wr;
        reg_rd_i = !wr;
        reg_addr_i = a;
        reg_wdata_i = d;
        @(negedge clk_sys_i);
        ack = reg_ack_o;
        err = reg_err_o;
        q = reg_rdata_o;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
    endtask

    task automatic wreg(input logic [15:0] a, input logic [15:0] d, input logic bad);
        logic ack, err;
        logic [15:0] q;
        bus(1'b1, a, d, ack, err, q);
        check_word({14'h0000, ack, err}, bad ? 16'h0001 : 16'h0002);
    endtask

    task automatic rreg(input logic [15:0] a, input logic [15:0] exp);
        logic ack, err;
        logic [15:0] q;
        bus(1'b0, a, 16'h0000, ack, err, q);
        check_word({q[15:0]}, exp);
        check_bit(ack, 1'b1);
    endtask

    task automatic test_defaults;
        rreg(16'h0300, 16'h007f);
        rreg(16'h0302, 16'h0203);
        rreg(16'h0304, 16'h0006);
        rreg(16'h0306, 16'h0000);
        rreg(16'h0308, 16'h0000);
        rreg(16'h030a, 16'h0000);
        rreg(16'h030e, 16'h0000);
        check_word({9'h000, group_num_o, axis_num_o}, 16'h007f);
        check_word(16'(link_cfg_o), 16'h0692);
        check_bit(usb_1m_o, 1'b1);
        $display("test defaults done");
    endtask

    task automatic test_node_address;
        wreg(16'h0300, 16'h0000, 1'b1);
        wreg(16'h0300, 16'h0080, 1'b1);
        wreg(16'h0300, 16'h00ff, 1'b1);
        wreg(16'h0300, 16'h0001, 1'b0);
        check_word({9'h000, group_num_o, axis_num_o}, 16'h0001);
        wreg(16'h0300, 16'h005a, 1'b0);
        rreg(16'h0300, 16'h005a);
        check_word({9'h000, group_num_o, axis_num_o}, 16'h005a);
        $display("test node address done");
    endtask

    task automatic test_speed;
        wreg(16'h0302, 16'h0010, 1'b1);
        wreg(16'h0302, 16'h0006, 1'b1);
        wreg(16'h0302, 16'h0500, 1'b1);
        for (int c = 0; c < 5; c++)
        begin
            for (int u = 0; u < 6; u++)
            begin
                wreg({4'h0, 4'(c), 4'h1, 4'(u)}, 16'h0000, 1'b1);
                wreg(16'h0302, {4'h0, 4'(c), 4'h0, 4'(u)}, 1'b0);
                check_word(16'(link_cfg_o[11:6]), {10'h000, 3'(u), 3'(c)});
            end
        end
        rreg(16'h0302, 16'h0405);
        reg_canopen_i = 1'b1;
        wreg(16'h0302, 16'h0102, 1'b0);
        reg_canopen_i = 1'b0;
        rreg(16'h0302, 16'h0105);
        check_bit(usb_1m_o, 1'b1);
        $display("test speed done");
    endtask

    task automatic test_protocol;
        for (int p = 0; p < 9; p++)
        begin
            wreg(16'h0304, 16'(p), 1'b0);
            check_word(16'(link_cfg_o[5:1]), 16'(PT[p]));
        end
        wreg(16'h0304, 16'h0009, 1'b1);
        rreg(16'h0304, 16'h0008);
        $display("test protocol done");
    endtask

    task automatic test_misc_regs;
        wreg(16'h030a, 16'h0001, 1'b0);
        check_bit(link_cfg_o.rs485_sel, 1'b1);
        wreg(16'h030a, 16'h0002, 1'b1);
        wreg(16'h030a, 16'h0000, 1'b0);
        check_bit(link_cfg_o.rs485_sel, 1'b0);
        wreg(16'h0306, 16'h0002, 1'b1);
        wreg(16'h0306, 16'h0001, 1'b0);
        check_bit(decel_stop_o, 1'b0);
        wreg(16'h0308, 16'h0015, 1'b1);
        wreg(16'h0308, 16'h0014, 1'b0);
        wreg(16'h0308, 16'h0000, 1'b0);
        check_bit(comm_fault_o, 1'b0);
        wreg(16'h030e, 16'h03e9, 1'b1);
        wreg(16'h0310, 16'h0001, 1'b1);
        rreg(16'h0310, 16'h0000);
        $display("test misc registers done");
    endtask

    // accept/drop shown during the strobe; exactly one reply when accepted
    task automatic frame(input logic [7:0] a, input logic acc, input int gap);
        logic [15:0] n;
        n = 16'h0000;
        u_host.send(a, gap);
        #1;
        check_word({14'h0000, frame_accept_o, frame_drop_o}, acc ? 16'h0002 : 16'h0001);
        u_host.finish();
        for (int i = 0; i < 4; i++)
        begin
            if (i > 0)
                @(negedge clk_sys_i);
            n = n + 16'(reply_go_o);
        end
        check_word(n, 16'(acc));
    endtask

    task automatic test_frames;
        wreg(16'h0300, 16'h0023, 1'b0);
        frame(8'h23, 1'b1, 0);
        frame(8'hff, 1'b1, 3);
        frame(8'h7f, 1'b0, 0);
        frame(8'h00, 1'b0, 1);
        frame(8'h24, 1'b0, 0);
        check_bit(comm_fault_o, 1'b0);
        $display("test frames done");
    endtask

    // reply held back two ms: still pending after one, exactly one pulse in all
    task automatic test_reply_delay;
        int n;
        n = 0;
        wreg(16'h030e, 16'h0002, 1'b0);
        rreg(16'h030e, 16'h0002);
        u_host.send(8'h23, 0);
        u_host.finish();
        for (int i = 0; i < 3 * MS; i++)
        begin
            if (i == MS)
                check_bit(reply_busy_o, 1'b1);
            n = n + int'(reply_go_o);
            @(negedge clk_sys_i);
        end
        check_word(16'(n), 16'h0001);
        check_bit(reply_busy_o, 1'b0);
        wreg(16'h030e, 16'h0000, 1'b0);
        $display("test reply delay done");
    endtask

    // one-second timeout counted from the write edge, then cleared by traffic
    task automatic test_timeout;
        wreg(16'h0306, 16'h0001, 1'b0);
        wreg(16'h0308, 16'h0001, 1'b0);
        repeat (1000 * MS - 1) @(negedge clk_sys_i);
        check_bit(comm_fault_o, 1'b0);
        @(negedge clk_sys_i);
        check_bit(comm_fault_o, 1'b1);
        check_bit(decel_stop_o, 1'b1);
        wreg(16'h0306, 16'h0000, 1'b0);
        check_word({14'h0000, comm_fault_o, decel_stop_o}, 16'h0002);
        frame(8'h23, 1'b1, 0);
        check_bit(comm_fault_o, 1'b0);
        wreg(16'h0308, 16'h0000, 1'b0);
        check_bit(comm_fault_o, 1'b0);
        $display("test timeout done");
    endtask

    initial
    begin
        repeat (12) @(negedge clk_sys_i);
        reset_n_i = 1'b1;
        test_defaults();
        test_node_address();
        test_speed();
        test_protocol();
        test_misc_regs();
        test_frames();
        test_reply_delay();
        test_timeout();
        complete_run();
    end
endmodule
